// ### halt_pkg.sv
// Purpose: Shared constants for the freeze, gating and encoder register block
// Assumes: 32-bit AHB-Lite data, one register per aligned word
// Notes: Register indices are word indices; byte address is four times the index
package halt_pkg;
  // Register word indices and byte addresses
  localparam logic [7:0] IDX_FREEZE_STOP_CONFIG = 8'h4e;
  localparam logic [7:0] IDX_RESET_AND_GATING = 8'h4f;
  localparam logic [7:0] IDX_ENCODER_POSITION = 8'h50;
  localparam logic [7:0] IDX_ENCODER_CAPTURED = 8'h60;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h61;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h62;
  localparam logic [7:0] IDX_BLOCK_STATUS = 8'h63;
  localparam int ADDR_W = 10;
  localparam logic [ADDR_W-1:0] ADDR_FREEZE_STOP_CONFIG = {IDX_FREEZE_STOP_CONFIG, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_RESET_AND_GATING = {IDX_RESET_AND_GATING, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_ENCODER_POSITION = {IDX_ENCODER_POSITION, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_ENCODER_CAPTURED = {IDX_ENCODER_CAPTURED, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_BLOCK_STATUS = {IDX_BLOCK_STATUS, 2'b00};

  // Freeze configuration fields
  localparam int DECEL_LSB = 0;
  localparam int DECEL_W = 24;
  localparam int SCALE_LSB = 24;
  localparam int SCALE_W = 8;
  localparam int DECEL_FRAC_BITS = 37;
  localparam logic [31:0] FREEZE_STOP_CONFIG_RESET = 32'h0000_0000;

  // Reset and gating fields
  localparam int GATE_LSB = 0;
  localparam int GATE_W = 3;
  localparam int KEY_LSB = 8;
  localparam int KEY_W = 24;
  localparam logic [2:0] GATE_OFF = 3'h0;
  localparam logic [2:0] GATE_ON = 3'h7;
  localparam logic [23:0] RESET_KEY = 24'h52_5354;
  localparam logic [31:0] RESET_AND_GATING_RESET = 32'h0000_0000;

  // Encoder registers
  localparam logic [31:0] ENCODER_RESET = 32'h0000_0000;

  // Interrupt status bits
  localparam int IRQ_W = 3;
  localparam int IRQ_HALT_DONE = 0;
  localparam int IRQ_LATCH = 1;
  localparam int IRQ_CFG_REJECT = 2;

  // Block status bits
  localparam int ST_CFG_WRITTEN = 0;
  localparam int ST_MOTION_SEEN = 1;
  localparam int ST_HALT_ACTIVE = 2;
  localparam int ST_STOP_LEVEL_N = 3;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HTRANS_SEQ = 2'b11;
  localparam logic HRESP_OKAY = 1'b0;
endpackage

// ### sync_two_flop.sv
// Purpose: Two-flop synchroniser for asynchronous level inputs
// Assumes: Input changes slowly compared with clk
// Notes: The first stage feeds only the second stage
`timescale 1ns/100ps
module sync_two_flop #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk, // Sampling clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic [WIDTH-1:0] async_in, // Level from outside the clock domain
  output logic [WIDTH-1:0] sync_out // Synchronised level
);
  logic [WIDTH-1:0] stage_a;

  // Metastability guard: each bit passes two flops
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          stage_a[i] <= INIT[i];
          sync_out[i] <= INIT[i];
        end else begin
          stage_a[i] <= async_in[i];
          sync_out[i] <= stage_a[i];
        end
      end
    end
  endgenerate
endmodule

// ### halt_ramp.sv
// Purpose: Linear stop ramp used when the stop request pin is asserted
// Assumes: start_vel is sampled on start; hold stays high while stopped
// Notes: Speed magnitude carries DECEL_FRAC_BITS fraction bits below the velocity LSB
`timescale 1ns/100ps
module halt_ramp
  import halt_pkg::*;
#(
  parameter int VEL_W = 32
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic clear, // Internal soft reset, one cycle
  input wire logic start, // Stop request began, one cycle
  input wire logic hold, // Stop request still asserted
  input wire logic hard, // Stop at once, no ramp
  input wire logic signed [VEL_W-1:0] start_vel, // Velocity when the stop began
  input wire logic [DECEL_W-1:0] decel, // Decrement per cycle, scaled by 2^-37
  output logic active, // Stop in progress or motor held stopped
  output logic signed [VEL_W-1:0] velocity, // Commanded velocity while active
  output logic done // Stop has completed, one cycle
);
  typedef enum logic [1:0] {IDLE, RAMP, STOPPED} ramp_state_t;
  localparam int MAG_W = VEL_W + DECEL_FRAC_BITS;

  ramp_state_t state;
  logic [MAG_W-1:0] mag;
  logic negative;
  logic [VEL_W-1:0] start_mag;
  logic [MAG_W-1:0] decel_ext;
  logic [VEL_W-1:0] mag_int;

  assign start_mag = start_vel[VEL_W-1] ? VEL_W'(-start_vel) : VEL_W'(start_vel);
  assign decel_ext = MAG_W'(decel);
  assign mag_int = mag[MAG_W-1:DECEL_FRAC_BITS];

  // Ramp sequencing; releasing the pin abandons the stop at any point
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= IDLE;
      mag <= '0;
      negative <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (clear || !hold) begin
        state <= IDLE;
        mag <= '0;
      end else begin
        unique case (state)
          IDLE: begin
            if (start && (hard || start_mag == '0)) begin
              state <= STOPPED;
              mag <= '0;
              done <= 1'b1;
            end else if (start) begin
              state <= RAMP;
              mag <= {start_mag, {DECEL_FRAC_BITS{1'b0}}};
              negative <= start_vel[VEL_W-1];
            end
          end
          RAMP: begin
            if (mag <= decel_ext) begin
              mag <= '0;
              state <= STOPPED;
              done <= 1'b1;
            end else begin
              mag <= mag - decel_ext;
            end
          end
          STOPPED: begin
            mag <= '0;
          end
        endcase
      end
    end
  end

  // Registered flags; velocity shows the start value with active, so its magnitude never rises
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      velocity <= '0;
      active <= 1'b0;
    end else begin
      active <= hold && !clear && (state != IDLE || start);
      if (state == IDLE) begin
        velocity <= (start && !hard && start_mag != '0) ? start_vel : '0;
      end else begin
        velocity <= negative ? VEL_W'(-mag_int) : mag_int;
      end
    end
  end
endmodule

// ### halt_regs.sv
// Purpose: Freeze stop, clock gating, soft reset and encoder registers behind AHB-Lite
// Assumes: Single-word transfers; ramp, encoder and motion inputs are on hclk
// Notes: Zero wait states; read data registered in the address phase
//
// Summary of operation
// - Freeze config writable once, before motion
// - Stop pin low starts linear ramp stop in direct mode; other modes stop at once
// - Zero deceleration gives an immediate stop
// - Per-cycle decrement is deceleration over 2^37
// - Stop pin low applies freeze current scale
// - Zero scale keeps scale active at stop
// - Gating field 0 off, 7 on
// - Key in upper bits fires internal reset
// - Signed encoder position, read and write
// - Read-only encoder copy captured on trigger
`timescale 1ns/100ps
module halt_regs
  import halt_pkg::*;
#(
  parameter int VEL_W = 32
) (
  input wire logic hclk, // System clock, 40 MHz
  input wire logic hresetn, // Asynchronous reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size, word only
  input wire logic hready, // Bus ready in
  input wire logic [31:0] hwdata, // Write data
  output logic [31:0] hrdata, // Read data
  output logic hreadyout, // Slave ready
  output logic hresp, // Response, always OKAY
  input wire logic stop_request_n, // Freeze pin, active low, asynchronous
  input wire logic direct_mode, // Ramp runs in direct mode
  input wire logic motion_active, // Ramp generator is moving
  input wire logic signed [VEL_W-1:0] ramp_velocity, // Present ramp velocity
  input wire logic [7:0] run_scale, // Scaling value in normal running
  input wire logic enc_step, // Encoder count, one cycle
  input wire logic enc_dir, // Encoder count direction, 1 is down
  input wire logic enc_latch_trigger, // Capture encoder position, one cycle
  output logic halt_active, // Freeze stop owns the motion
  output logic signed [VEL_W-1:0] halt_velocity, // Velocity during freeze stop
  output logic [7:0] motor_scale, // Current scaling to apply
  output logic clk_gate_en, // Clock gating enable
  output logic soft_reset, // Internal reset pulse
  output logic irq // Interrupt, level, active high
);
  // Register storage
  logic [31:0] freeze_stop_config;
  logic [31:0] reset_and_gating_control;
  logic signed [31:0] encoder_position;
  logic signed [31:0] encoder_captured_position;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic cfg_written;
  logic motion_seen;

  // Bus pipeline
  logic wr_pending;
  logic [ADDR_W-1:0] wr_addr;
  logic addr_valid;
  logic wr_now;
  logic [31:0] next_rdata;

  // Stop request path
  logic stop_level_n;
  logic stop_level_d;
  logic stop_start;
  logic stop_hold;
  logic ramp_done;
  logic ramp_active;
  logic [7:0] held_scale;
  logic hard_stop;

  // Register decode helpers
  logic cfg_write_try;
  logic cfg_write_ok;
  logic [IRQ_W-1:0] irq_set;

  // Pin passes two flops before any logic sees it
  sync_two_flop #(
    .WIDTH(1),
    .INIT(1'b1)
  ) u_stop_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .async_in(stop_request_n),
    .sync_out(stop_level_n)
  );

  // Edge detect on the synchronised level only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stop_level_d <= 1'b1;
    end else begin
      stop_level_d <= stop_level_n;
    end
  end

  assign stop_hold = !stop_level_n;
  assign stop_start = stop_level_d && !stop_level_n;
  // Frequency mode offers no freeze ramp, so it falls back to a hard stop
  assign hard_stop = (freeze_stop_config[DECEL_LSB +: DECEL_W] == '0) || !direct_mode;

  halt_ramp #(
    .VEL_W(VEL_W)
  ) u_ramp (
    .clk(hclk),
    .rst_n(hresetn),
    .clear(soft_reset),
    .start(stop_start),
    .hold(stop_hold),
    .hard(hard_stop),
    .start_vel(ramp_velocity),
    .decel(freeze_stop_config[DECEL_LSB +: DECEL_W]),
    .active(ramp_active),
    .velocity(halt_velocity),
    .done(ramp_done)
  );

  assign halt_active = ramp_active;

  // Address phase capture; any access the master starts is accepted at once
  assign addr_valid = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  assign wr_now = wr_pending;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending <= 1'b0;
      wr_addr <= '0;
    end else if (hready) begin
      wr_pending <= addr_valid && hwrite;
      wr_addr <= haddr[ADDR_W-1:0];
    end
  end

  // Bus handshake outputs are constant: no wait states, no errors
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
    end
  end

  // Read mux; unmapped words and reserved bits read as zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (haddr[ADDR_W-1:0])
      ADDR_FREEZE_STOP_CONFIG: next_rdata = freeze_stop_config;
      ADDR_RESET_AND_GATING: next_rdata = reset_and_gating_control;
      ADDR_ENCODER_POSITION: next_rdata = encoder_position;
      ADDR_ENCODER_CAPTURED: next_rdata = encoder_captured_position;
      ADDR_IRQ_STATUS: next_rdata = 32'(irq_status);
      ADDR_IRQ_MASK: next_rdata = 32'(irq_mask);
      ADDR_BLOCK_STATUS: begin
        next_rdata[ST_CFG_WRITTEN] = cfg_written;
        next_rdata[ST_MOTION_SEEN] = motion_seen;
        next_rdata[ST_HALT_ACTIVE] = ramp_active;
        next_rdata[ST_STOP_LEVEL_N] = stop_level_n;
      end
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data is ready for the data phase that follows the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_valid && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

  // Motion seen since the last reset closes the configuration window
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      motion_seen <= 1'b0;
    end else if (soft_reset) begin
      motion_seen <= 1'b0;
    end else if (motion_active) begin
      motion_seen <= 1'b1;
    end
  end

  // Freeze configuration: first write after reset wins unless motion came first; later ones dropped
  assign cfg_write_try = wr_now && wr_addr == ADDR_FREEZE_STOP_CONFIG;
  assign cfg_write_ok = cfg_write_try && !cfg_written && !motion_seen;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      freeze_stop_config <= FREEZE_STOP_CONFIG_RESET;
      cfg_written <= 1'b0;
    end else if (soft_reset) begin
      freeze_stop_config <= FREEZE_STOP_CONFIG_RESET;
      cfg_written <= 1'b0;
    end else if (cfg_write_ok) begin
      freeze_stop_config <= hwdata;
      cfg_written <= 1'b1;
    end
  end

  // Gating field and reset key; the key field clears itself after firing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reset_and_gating_control <= RESET_AND_GATING_RESET;
      soft_reset <= 1'b0;
    end else begin
      soft_reset <= 1'b0;
      if (soft_reset) begin
        reset_and_gating_control[KEY_LSB +: KEY_W] <= '0;
      end else if (wr_now && wr_addr == ADDR_RESET_AND_GATING) begin
        reset_and_gating_control[GATE_LSB +: GATE_W] <= hwdata[GATE_LSB +: GATE_W];
        reset_and_gating_control[KEY_LSB +: KEY_W] <= hwdata[KEY_LSB +: KEY_W];
        soft_reset <= hwdata[KEY_LSB +: KEY_W] == RESET_KEY;
      end
    end
  end

  // Gating turns on only for the full-on code; other codes leave it off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_gate_en <= 1'b0;
    end else begin
      clk_gate_en <= reset_and_gating_control[GATE_LSB +: GATE_W] == GATE_ON;
    end
  end

  // Encoder position: a software write beats a count in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      encoder_position <= ENCODER_RESET;
    end else if (soft_reset) begin
      encoder_position <= ENCODER_RESET;
    end else if (wr_now && wr_addr == ADDR_ENCODER_POSITION) begin
      encoder_position <= hwdata;
    end else if (enc_step) begin
      encoder_position <= enc_dir ? encoder_position - 32'sd1 : encoder_position + 32'sd1;
    end
  end

  // Captured copy takes the position as it stood before this cycle's count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      encoder_captured_position <= ENCODER_RESET;
    end else if (soft_reset) begin
      encoder_captured_position <= ENCODER_RESET;
    end else if (enc_latch_trigger) begin
      encoder_captured_position <= encoder_position;
    end
  end

  // Scale held from the moment the stop began, for the zero-scale case
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      held_scale <= 8'h00;
    end else if (stop_start) begin
      held_scale <= run_scale;
    end
  end

  // Motor scaling: freeze scale while the pin is low, else running scale
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      motor_scale <= 8'h00;
    end else if (stop_hold && !stop_start) begin
      if (freeze_stop_config[SCALE_LSB +: SCALE_W] != 8'h00) begin
        motor_scale <= freeze_stop_config[SCALE_LSB +: SCALE_W];
      end else begin
        motor_scale <= held_scale;
      end
    end else begin
      motor_scale <= run_scale;
    end
  end

  // Event sources for the sticky status bits
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_HALT_DONE] = ramp_done;
    irq_set[IRQ_LATCH] = enc_latch_trigger;
    irq_set[IRQ_CFG_REJECT] = cfg_write_try && !cfg_write_ok;
  end

  // Write one to clear; a new event in the same cycle keeps its bit set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= '0;
    end else if (wr_now && wr_addr == ADDR_IRQ_STATUS) begin
      irq_status <= (irq_status & ~hwdata[IRQ_W-1:0]) | irq_set;
    end else begin
      irq_status <= irq_status | irq_set;
    end
  end

  // Mask register, one enable bit per status bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask <= '0;
    end else if (wr_now && wr_addr == ADDR_IRQ_MASK) begin
      irq_mask <= hwdata[IRQ_W-1:0];
    end
  end

  // Registered interrupt line, so it lags a status change by one cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end
endmodule

// ### halt_regs_sva.sv
// Purpose: Port checks of halt_regs
// Assumes: Single hclk domain
// Notes: Bound at the foot
`timescale 1ns/100ps
module halt_regs_sva
  import halt_pkg::*;
#(
  parameter int VEL_W = 32
) (
  input wire logic hclk, // System clock
  input wire logic hresetn, // Asynchronous reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic hready, // Bus ready in
  input wire logic [31:0] hwdata, // Write data
  input wire logic stop_request_n, // Freeze pin
  input wire logic direct_mode, // Direct mode level
  input wire logic [7:0] run_scale, // Running scale
  input wire logic halt_active, // Freeze stop active
  input wire logic signed [VEL_W-1:0] halt_velocity, // Stop ramp velocity
  input wire logic [7:0] motor_scale, // Applied scale
  input wire logic clk_gate_en, // Gating enable
  input wire logic soft_reset // Internal reset pulse
);
  logic wr_pend;
  logic [ADDR_W-1:0] wr_addr;
  logic [3:0] low_cnt;
  wire logic gate_bit = hwdata[GATE_W-1:0] == GATE_ON;
  wire logic gate_wr = wr_pend && hready && wr_addr == ADDR_RESET_AND_GATING;
  wire logic key_wr = gate_wr && hwdata[31:KEY_LSB] == RESET_KEY;

  // Marks a write data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end else if (hready) begin
      wr_pend <= hsel && htrans[1] && hwrite;
      wr_addr <= haddr[ADDR_W-1:0];
    end
  end

  // Low pin samples; soft reset parks it until a fresh fall
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_cnt <= '0;
    end else if (stop_request_n) begin
      low_cnt <= '0;
    end else if (soft_reset) begin
      low_cnt <= 4'hf;
    end else if (low_cnt != 4'hf) begin
      low_cnt <= low_cnt + 4'h1;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_gate_follow: assert property (gate_wr |-> ##2 clk_gate_en == $past(gate_bit, 2))
    else $error("gating enable stale");
  a_key_fires: assert property (key_wr |-> ##[1:2] soft_reset)
    else $error("no internal reset");
  a_reset_single: assert property (soft_reset |=> !soft_reset)
    else $error("reset pulse too long");
  a_reset_aborts: assert property (soft_reset |=> !halt_active)
    else $error("stop not aborted");
  a_halt_start: assert property (low_cnt == 4'h8 |-> halt_active)
    else $error("no stop with pin low");
  a_halt_release: assert property (stop_request_n [*6] |-> !halt_active)
    else $error("stop with pin high");
  a_scale_hold: assert property (disable iff (!hresetn || soft_reset)
    halt_active [*4] |-> $stable(motor_scale))
    else $error("scale moved in stop");
  a_scale_run: assert property ((hresetn && stop_request_n && !halt_active) [*4]
    |-> motor_scale == $past(run_scale))
    else $error("scale not running scale");
  a_freq_hard: assert property ((halt_active && !direct_mode) [*3] |-> halt_velocity == 0)
    else $error("no hard stop");
  a_ramp_down: assert property (halt_active && $past(halt_active) && $past(halt_velocity) >= 0
    |-> halt_velocity <= $past(halt_velocity))
    else $error("ramp velocity rose");
endmodule

bind halt_regs halt_regs_sva #(.VEL_W(VEL_W)) u_sva (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hwdata, .stop_request_n, .direct_mode, .run_scale, .halt_active, .halt_velocity, .motor_scale, .clk_gate_en,
  .soft_reset);

// ### tb_halt_regs.sv
// Purpose: Self-checking bench for halt_regs
// Assumes: hready tied back from hreadyout
// Notes: Ramp slope checked over a short span only
`timescale 1ns/100ps
module tb_halt_regs;
  import halt_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic stop_request_n = 1'b1;
  logic direct_mode = 1'b1;
  logic motion_active = 1'b0;
  logic signed [31:0] ramp_velocity = 32'h0000_0002;
  logic [7:0] run_scale = 8'h33;
  logic enc_step = 1'b0;
  logic enc_dir = 1'b0;
  logic enc_latch_trigger = 1'b0;
  logic hready;
  logic [31:0] hrdata;
  logic hresp;
  logic halt_active;
  logic signed [31:0] halt_velocity;
  logic [7:0] motor_scale;
  logic clk_gate_en;
  logic soft_reset;
  logic irq;
  int mismatches = 0;
  int checks_done = 0;
  localparam logic [31:0] CFG_A = 32'h5A10_0000;

  halt_regs #(.VEL_W(32)) uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata, .hrdata,
    .hreadyout(hready), .hresp, .stop_request_n, .direct_mode, .motion_active, .ramp_velocity, .run_scale, .enc_step,
    .enc_dir, .enc_latch_trigger, .halt_active, .halt_velocity, .motor_scale, .clk_gate_en, .soft_reset, .irq);

  // 40 MHz system clock
  always #12.5 hclk = ~hclk;

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One transfer, from just after an edge to the data-phase edge
  task automatic bus(input logic wr, input logic [9:0] addr, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {22'h00_0000, addr};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    if (wr) hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    check("bus response", {31'h0, HRESP_OKAY}, {31'h0, hresp});
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd_chk(input string what, input logic [9:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0000_0000, x);
    check(what, exp, x);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // Reset values; unmapped reads zero
  task automatic t_reset_values();
    logic [9:0] map[6] = '{ADDR_FREEZE_STOP_CONFIG, ADDR_RESET_AND_GATING, ADDR_ENCODER_POSITION,
      ADDR_ENCODER_CAPTURED, ADDR_IRQ_STATUS, ADDR_IRQ_MASK};
    foreach (map[i]) rd_chk("register reset value", map[i], 32'h0000_0000);
    wr(10'h3fc, 32'hFFFF_FFFF);
    rd_chk("unmapped read", 10'h3fc, 32'h0000_0000);
    check("gating after reset", 32'h0000_0000, {31'h0, clk_gate_en});
  endtask

  // First write sticks, a second one is dropped and flagged
  task automatic t_freeze_once();
    wr(ADDR_FREEZE_STOP_CONFIG, CFG_A);
    rd_chk("freeze config", ADDR_FREEZE_STOP_CONFIG, CFG_A);
    wr(ADDR_FREEZE_STOP_CONFIG, 32'hFFFF_FFFF);
    rd_chk("freeze config locked", ADDR_FREEZE_STOP_CONFIG, CFG_A);
    rd_chk("reject flag", ADDR_IRQ_STATUS, 32'h0000_0004);
    check("irq masked", 32'h0000_0000, {31'h0, irq});
    wr(ADDR_IRQ_STATUS, 32'h0000_0004);
    rd_chk("status cleared", ADDR_IRQ_STATUS, 32'h0000_0000);
  endtask

  // Only the value 7 turns gating on
  task automatic t_gating();
    logic [2:0] vals[3] = '{3'h7, 3'h3, 3'h0};
    foreach (vals[i]) begin
      wr(ADDR_RESET_AND_GATING, {29'h0, vals[i]});
      tick(2);
      check("gating enable", {31'h0, vals[i] == GATE_ON}, {31'h0, clk_gate_en});
      rd_chk("gating field", ADDR_RESET_AND_GATING, {29'h0, vals[i]});
    end
  endtask

  // Signed count through zero; read-only capture
  task automatic t_encoder();
    wr(ADDR_ENCODER_POSITION, 32'hFFFF_FFFE);
    for (int i = 0; i < 4; i++) begin
      enc_dir <= (i == 3);
      enc_step <= 1'b1;
      enc_latch_trigger <= (i == 3);
      tick(1);
      enc_step <= 1'b0;
      enc_latch_trigger <= 1'b0;
      tick(1);
    end
    rd_chk("encoder position", ADDR_ENCODER_POSITION, 32'h0000_0000);
    rd_chk("encoder capture", ADDR_ENCODER_CAPTURED, 32'h0000_0001);
    wr(ADDR_ENCODER_CAPTURED, 32'h1234_5678);
    rd_chk("capture read only", ADDR_ENCODER_CAPTURED, 32'h0000_0001);
  endtask

  // Sticky latch event, mask, write-one clear
  task automatic t_irq();
    rd_chk("latch event", ADDR_IRQ_STATUS, 32'h0000_0002);
    check("irq while masked", 32'h0000_0000, {31'h0, irq});
    wr(ADDR_IRQ_MASK, 32'h0000_0007);
    tick(2);
    check("irq unmasked", 32'h0000_0001, {31'h0, irq});
    wr(ADDR_IRQ_STATUS, 32'h0000_0002);
    tick(2);
    check("irq cleared", 32'h0000_0000, {31'h0, irq});
  endtask

  // Deceleration 0x100000 from speed 2: integer part is 1 after 1000 cycles
  task automatic t_ramp();
    stop_request_n <= 1'b0;
    tick(6);
    check("stop active", 32'h0000_0001, {31'h0, halt_active});
    check("freeze scale", 32'h0000_005A, {24'h0, motor_scale});
    tick(1000);
    check("ramp velocity", 32'h0000_0001, halt_velocity);
    rd_chk("no done yet", ADDR_IRQ_STATUS, 32'h0000_0000);
    stop_request_n <= 1'b1;
    tick(6);
    check("stop released", 32'h0000_0000, {31'h0, halt_active});
    check("run scale back", 32'h0000_0033, {24'h0, motor_scale});
  endtask

  // Key write: one-cycle internal reset, gating kept
  task automatic t_soft_reset();
    wr(ADDR_RESET_AND_GATING, {RESET_KEY, 8'h07});
    tick(1);
    check("internal reset", 32'h0000_0001, {31'h0, soft_reset});
    tick(1);
    check("reset pulse end", 32'h0000_0000, {31'h0, soft_reset});
    rd_chk("config cleared", ADDR_FREEZE_STOP_CONFIG, 32'h0000_0000);
    rd_chk("key self clear", ADDR_RESET_AND_GATING, 32'h0000_0007);
  endtask

  // Hard stop: zero velocity and a done event
  task automatic t_hard(input logic [31:0] cfg, input logic dm);
    t_soft_reset();
    wr(ADDR_FREEZE_STOP_CONFIG, cfg);
    direct_mode <= dm;
    ramp_velocity <= 32'h0000_0005;
    stop_request_n <= 1'b0;
    tick(4);
    run_scale <= 8'h44;
    tick(4);
    check("hard stop velocity", 32'h0000_0000, halt_velocity);
    check("held scale", 32'h0000_0033, {24'h0, motor_scale});
    rd_chk("done event", ADDR_IRQ_STATUS, 32'h0000_0001);
    check("done irq", 32'h0000_0001, {31'h0, irq});
    wr(ADDR_IRQ_STATUS, 32'h0000_0001);
    stop_request_n <= 1'b1;
    direct_mode <= 1'b1;
    run_scale <= 8'h33;
    tick(6);
  endtask

  // Motion before the first write locks the config
  task automatic t_locked();
    t_soft_reset();
    motion_active <= 1'b1;
    tick(1);
    motion_active <= 1'b0;
    wr(ADDR_FREEZE_STOP_CONFIG, CFG_A);
    rd_chk("late config dropped", ADDR_FREEZE_STOP_CONFIG, 32'h0000_0000);
    rd_chk("late config flag", ADDR_IRQ_STATUS, 32'h0000_0004);
    rd_chk("block status", ADDR_BLOCK_STATUS, 32'h0000_000A);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Tests take a little over a thousand cycles
  initial begin
    tick(20000);
    mismatches++;
    conclude();
  end

  initial begin
    tick(6);
    hresetn <= 1'b1;
    tick(1);
    t_reset_values();
    t_freeze_once();
    t_gating();
    t_encoder();
    t_irq();
    t_ramp();
    t_hard(32'h0000_0000, 1'b1);
    t_hard(32'h0000_1000, 1'b0);
    t_locked();
    conclude();
  end
endmodule
